// ### pkg/wake_status_defines.svh
// Constants for the wake-source and live-level status registers.
// Assumes 8-bit registers at 7-bit serial register addresses.
// What this block does
// - First wake-source register at address 46h, cleared by power-on or soft reset.
// - On restart the first register keeps bits 7,5,4,0; others read zero.
// - Bit 7 of the first register latches an automatic regulator mode change.
// - Bit 5 latches bus 0 wake, bit 4 timer wake, bit 0 wake pin.
// - Reserved bits of all three registers always read zero.
// - Wake flags are also set on a wake out of fail-safe mode.
// - Live-level register at address 48h; bit 0 shows the wake pin level.
// - Soft reset zeroes live bits 5,3,2,1; restart zeroes only bits 2,1.
// - Live bit 7 shows development mode; then watchdog faults cause no reset.
// - Live bit 6 is the strapped interrupt pin level selecting fail-safe entry.
// - Live bit 5 mirrors the fail-output count select bit.
// - Live bit 4 shows the supply configuration pin level.
// - Live bit 3 is the unlatched battery undervoltage comparator output.
// - Second register at address 49h; bit 7 latches battery undervoltage.
// - Second register bits 2,1,0 latch wakes from bus channels 3,2,1.
// - Second register cleared by reset; restart keeps bits 7,2,1,0 only.
// - Latched flags stay set until a host clear, a soft reset or a power-on reset.
`ifndef WAKE_STATUS_DEFINES_SVH
`define WAKE_STATUS_DEFINES_SVH
`define WS_ADDR_A 7'h46
`define WS_ADDR_LVL 7'h48
`define WS_ADDR_B 7'h49
`define WS_ZERO 8'h00
`define WS_A_RC_MASK 8'hB1
`define WS_A_KEEP 8'hB1
`define WS_B_RC_MASK 8'h87
`define WS_B_KEEP 8'h87
`define WS_LVL_SOFT_ZERO 8'h2E
`define WS_LVL_RESTART_ZERO 8'h06
`define WS_A_MODE_BIT 7
`define WS_A_BUS0_BIT 5
`define WS_A_TIMER_BIT 4
`define WS_A_PIN_BIT 0
`define WS_B_UV_BIT 7
`define WS_B_BUS1_BIT 0
`define WS_LVL_DEV_BIT 7
`define WS_LVL_CFG1_BIT 6
`define WS_LVL_FAIL_OUTPUT_COUNT_SELECT_BIT 5
`define WS_LVL_SUPPLY_CONFIG_PIN_BIT 4
`define WS_LVL_UV_BIT 3
`define WS_LVL_WAKE_BIT 0
`endif

// ### pkg/wake_status_pkg.sv
// Types shared by the status register bank.
// Assumes 8-bit registers and 7-bit register addresses.
package wake_status_pkg;
  typedef logic [7:0] reg8_t;
  typedef logic [6:0] addr_t;
  typedef enum logic [1:0] {ACC_NONE, ACC_READ, ACC_CLEAR, ACC_BOTH} access_t;
  typedef struct packed {
    reg8_t flags;
  } bank_state_t;
  typedef struct packed {
    logic strap_taken;
    reg8_t level;
  } level_state_t;
  typedef struct packed {
    reg8_t rd_data;
    logic rd_valid;
    logic rd_error;
    addr_t last_addr;
    logic wd_inhibit;
    logic failsafe_on_wd;
    logic fo_after_first;
  } top_state_t;
endpackage : wake_status_pkg

// ### pkg/flag_bank_if.sv
// Carrier between the register front end and one latched flag bank.
// Assumes one clock; all strobes are single-cycle and synchronous.
`timescale 1ns/1ps
`default_nettype none
interface flag_bank_if;
  wake_status_pkg::reg8_t set;
  logic clear;
  logic restart;
  logic soft_reset;
  wake_status_pkg::reg8_t value;
  modport ctrl (output set, output clear, output restart, output soft_reset, input value);
  modport bank (input set, input clear, input restart, input soft_reset, output value);
endinterface : flag_bank_if
`default_nettype wire

// ### hdl/status_flag_bank.sv
// One 8-bit register of sticky flags with host clear and restart retention.
// Assumes set, clear and reset strobes are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
`include "wake_status_defines.svh"
module status_flag_bank #(
  parameter logic [7:0] RC_MASK = `WS_A_RC_MASK,
  parameter logic [7:0] KEEP_MASK = `WS_A_KEEP
) (
  input wire logic clk,
  input wire logic rst_n,
  flag_bank_if.bank fb
);
  wake_status_pkg::bank_state_t st;
  wake_status_pkg::bank_state_t next_st;
  if ((KEEP_MASK & ~RC_MASK) != `WS_ZERO) begin : g_bad_mask
    $error("Restart may only keep latched flag bits");
  end
  always_comb begin
    next_st = st;
    if (fb.soft_reset) begin
      next_st.flags = `WS_ZERO;
    end else if (fb.restart) begin
      next_st.flags = st.flags & KEEP_MASK;
    end else if (fb.clear) begin
      next_st.flags = `WS_ZERO;
    end
    // Sets are or-ed in last so an event is never lost to any clear
    next_st.flags = (next_st.flags | fb.set) & RC_MASK;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign fb.value = st.flags;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_set_beats_clear: assert property (
    (fb.clear || fb.restart) |=> ((($past(fb.set) & RC_MASK) & ~fb.value) == `WS_ZERO))
    else $error("Flag set lost to a simultaneous clear");
  chk_flags_hold: assert property (
    (!fb.clear && !fb.restart && !fb.soft_reset && fb.set == `WS_ZERO) |=> $stable(fb.value))
    else $error("Latched flags changed without cause");
  chk_restart_keep: assert property (
    (fb.restart && !fb.soft_reset && fb.set == `WS_ZERO)
      |=> fb.value == ($past(fb.value) & KEEP_MASK))
    else $error("Restart did not keep exactly the retained bits");
  chk_soft_zero: assert property (
    (fb.soft_reset && fb.set == `WS_ZERO) |=> fb.value == `WS_ZERO)
    else $error("Soft reset left a flag set");
endmodule : status_flag_bank
`default_nettype wire

// ### hdl/live_level_sampler.sv
// Live-level register: registered copies of pins, comparator and config bits.
// Assumes inputs are synchronous; the interrupt pin is read as a strap.
`timescale 1ns/1ps
`default_nettype none
`include "wake_status_defines.svh"
module live_level_sampler (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_reset,
  input wire logic restart,
  input wire logic dev_mode,
  input wire logic interrupt_out_pin_pin,
  input wire logic fail_output_count_select_sel,
  input wire logic supply_config_pin_pin,
  input wire logic uv_live,
  input wire logic wake_pin,
  output var wake_status_pkg::reg8_t level
);
  wake_status_pkg::level_state_t st;
  wake_status_pkg::level_state_t next_st;
  always_comb begin
    next_st = st;
    next_st.strap_taken = 1'b1;
    next_st.level = `WS_ZERO;
    next_st.level[`WS_LVL_DEV_BIT] = dev_mode;
    // Strap is caught once after reset release and again on soft reset
    next_st.level[`WS_LVL_CFG1_BIT] = (!st.strap_taken || soft_reset)
                                      ? interrupt_out_pin_pin : st.level[`WS_LVL_CFG1_BIT];
    next_st.level[`WS_LVL_FAIL_OUTPUT_COUNT_SELECT_BIT] = fail_output_count_select_sel;
    next_st.level[`WS_LVL_SUPPLY_CONFIG_PIN_BIT] = supply_config_pin_pin;
    next_st.level[`WS_LVL_UV_BIT] = uv_live;
    next_st.level[`WS_LVL_WAKE_BIT] = wake_pin;
    if (soft_reset) begin
      next_st.level = next_st.level & ~`WS_LVL_SOFT_ZERO;
    end
    if (restart) begin
      next_st.level = next_st.level & ~`WS_LVL_RESTART_ZERO;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign level = st.level;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_soft_live_zero: assert property (
    soft_reset |=> (level & `WS_LVL_SOFT_ZERO) == `WS_ZERO)
    else $error("Soft reset did not zero the live bits");
  chk_strap_stable: assert property (
    (st.strap_taken && !soft_reset) |=> $stable(level[`WS_LVL_CFG1_BIT]))
    else $error("Strapped configuration level moved");
  chk_uv_live_follows: assert property (
    !soft_reset |=> level[`WS_LVL_UV_BIT] == $past(uv_live))
    else $error("Undervoltage live bit not following the comparator");
endmodule : live_level_sampler
`default_nettype wire

// ### hdl/wake_source_level_status.sv
// Wake-source and live-level status registers behind the serial register port.
// Assumes the serial frame logic delivers one-cycle read and clear strobes with
// a 7-bit register address, and that wake and mode events arrive as one-cycle
// pulses already qualified by the mode controller.
`timescale 1ns/1ps
`default_nettype none
`include "wake_status_defines.svh"
module wake_source_level_status (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic SOFT_RESET,
  input wire logic RESTART,
  input wire logic [6:0] REG_ADDR,
  input wire logic REG_READ,
  input wire logic REG_CLEAR,
  output logic [7:0] RD_DATA,
  output logic RD_VALID,
  output logic RD_ERROR,
  input wire logic REGULATOR_AUTO_MODE_CHANGE,
  input wire logic [3:0] BUS_WAKE,
  input wire logic CYCLIC_TIMER_WAKE,
  input wire logic WAKE_PIN_WAKE,
  input wire logic WAKE_INPUT_PIN,
  input wire logic BATTERY_SENSE_UV,
  input wire logic DEV_MODE,
  input wire logic INTERRUPT_OUT_PIN,
  input wire logic FAIL_OUTPUT_COUNT_SELECT,
  input wire logic SUPPLY_CONFIG_PIN,
  output logic WD_RESET_INHIBIT,
  output logic FAILSAFE_ON_WD_FAIL,
  output logic FAIL_OUTPUT_AFTER_FIRST
);

  wake_status_pkg::top_state_t st;
  wake_status_pkg::top_state_t next_st;
  wake_status_pkg::reg8_t live_level;
  wake_status_pkg::access_t access;
  wake_status_pkg::reg8_t set_a;
  wake_status_pkg::reg8_t set_b;

  flag_bank_if bank_a_if ();
  flag_bank_if bank_b_if ();

  // Address decode for the error flag, shared by the read and clear paths
  function automatic logic is_mapped(input wake_status_pkg::addr_t addr);
    is_mapped = (addr == `WS_ADDR_A) || (addr == `WS_ADDR_LVL) ||
                (addr == `WS_ADDR_B);
  endfunction : is_mapped

  function automatic wake_status_pkg::reg8_t read_mux(
    input wake_status_pkg::addr_t addr,
    input wake_status_pkg::reg8_t a,
    input wake_status_pkg::reg8_t lvl,
    input wake_status_pkg::reg8_t b
  );
    case (addr)
      `WS_ADDR_A: read_mux = a;
      `WS_ADDR_LVL: read_mux = lvl;
      `WS_ADDR_B: read_mux = b;
      default: read_mux = `WS_ZERO;
    endcase
  endfunction : read_mux

  // Event sources. No mode gating here: a wake out of fail-safe sets the
  // same flag as a wake out of a low-power mode.
  always_comb begin
    set_a = `WS_ZERO;
    set_a[`WS_A_MODE_BIT] = REGULATOR_AUTO_MODE_CHANGE;
    set_a[`WS_A_BUS0_BIT] = BUS_WAKE[0];
    set_a[`WS_A_TIMER_BIT] = CYCLIC_TIMER_WAKE;
    set_a[`WS_A_PIN_BIT] = WAKE_PIN_WAKE;
  end

  // Undervoltage latches from the registered comparator copy, so it stays
  // set while the condition persists even across a host clear.
  always_comb begin
    set_b = `WS_ZERO;
    set_b[`WS_B_UV_BIT] = live_level[`WS_LVL_UV_BIT];
    for (int i = 1; i < 4; i++) begin
      set_b[`WS_B_BUS1_BIT + i - 1] = BUS_WAKE[i];
    end
  end

  always_comb begin
    bank_a_if.set = set_a;
    bank_a_if.clear = REG_CLEAR && (REG_ADDR == `WS_ADDR_A);
    bank_a_if.restart = RESTART;
    bank_a_if.soft_reset = SOFT_RESET;
    bank_b_if.set = set_b;
    bank_b_if.clear = REG_CLEAR && (REG_ADDR == `WS_ADDR_B);
    bank_b_if.restart = RESTART;
    bank_b_if.soft_reset = SOFT_RESET;
  end

  status_flag_bank #(
    .RC_MASK(`WS_A_RC_MASK),
    .KEEP_MASK(`WS_A_KEEP)
  ) u_bank_a (
    .clk(CLK),
    .rst_n(RST_N),
    .fb(bank_a_if.bank)
  );

  status_flag_bank #(
    .RC_MASK(`WS_B_RC_MASK),
    .KEEP_MASK(`WS_B_KEEP)
  ) u_bank_b (
    .clk(CLK),
    .rst_n(RST_N),
    .fb(bank_b_if.bank)
  );

  live_level_sampler u_level (
    .clk(CLK),
    .rst_n(RST_N),
    .soft_reset(SOFT_RESET),
    .restart(RESTART),
    .dev_mode(DEV_MODE),
    .interrupt_out_pin_pin(INTERRUPT_OUT_PIN),
    .fail_output_count_select_sel(FAIL_OUTPUT_COUNT_SELECT),
    .supply_config_pin_pin(SUPPLY_CONFIG_PIN),
    .uv_live(BATTERY_SENSE_UV),
    .wake_pin(WAKE_INPUT_PIN),
    .level(live_level)
  );

  always_comb begin
    case ({REG_CLEAR, REG_READ})
      2'b01: access = wake_status_pkg::ACC_READ;
      2'b10: access = wake_status_pkg::ACC_CLEAR;
      2'b11: access = wake_status_pkg::ACC_BOTH;
      default: access = wake_status_pkg::ACC_NONE;
    endcase
  end

  // A read in the same cycle as a clear returns the value before the clear,
  // so read-and-clear in one frame never loses a flag to the host.
  always_comb begin
    next_st = st;
    next_st.rd_valid = 1'b0;
    next_st.rd_error = 1'b0;
    case (access)
      wake_status_pkg::ACC_READ,
      wake_status_pkg::ACC_BOTH: begin
        next_st.rd_valid = 1'b1;
        next_st.rd_error = !is_mapped(REG_ADDR);
        next_st.last_addr = REG_ADDR;
        next_st.rd_data = read_mux(REG_ADDR, bank_a_if.value, live_level,
                                   bank_b_if.value);
      end
      wake_status_pkg::ACC_CLEAR: begin
        // Clearing the live register is harmless and ignored
        next_st.rd_error = !is_mapped(REG_ADDR);
      end
      default: begin
        next_st.rd_valid = 1'b0;
      end
    endcase
    next_st.wd_inhibit = live_level[`WS_LVL_DEV_BIT];
    next_st.failsafe_on_wd = !live_level[`WS_LVL_CFG1_BIT];
    next_st.fo_after_first = live_level[`WS_LVL_FAIL_OUTPUT_COUNT_SELECT_BIT];
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign RD_DATA = st.rd_data;
  assign RD_VALID = st.rd_valid;
  assign RD_ERROR = st.rd_error;
  assign WD_RESET_INHIBIT = st.wd_inhibit;
  assign FAILSAFE_ON_WD_FAIL = st.failsafe_on_wd;
  assign FAIL_OUTPUT_AFTER_FIRST = st.fo_after_first;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  sequence s_read_a;
    REG_READ && (REG_ADDR == `WS_ADDR_A);
  endsequence

  sequence s_read_lvl;
    REG_READ && (REG_ADDR == `WS_ADDR_LVL);
  endsequence

  sequence s_read_b;
    REG_READ && (REG_ADDR == `WS_ADDR_B);
  endsequence

  sequence s_quiet;
    !SOFT_RESET && !RESTART;
  endsequence

  chk_read_a_value: assert property (
    s_read_a |=> RD_VALID && !RD_ERROR && RD_DATA == $past(bank_a_if.value))
    else $error("Read of the first wake register returned a wrong value");

  chk_mode_change_set: assert property (
    (REGULATOR_AUTO_MODE_CHANGE && !SOFT_RESET)
      |=> bank_a_if.value[`WS_A_MODE_BIT])
    else $error("Regulator mode change flag not set next cycle");

  chk_wake_bits_set: assert property (
    (WAKE_PIN_WAKE && CYCLIC_TIMER_WAKE && BUS_WAKE[0])
      |=> bank_a_if.value[`WS_A_PIN_BIT] && bank_a_if.value[`WS_A_TIMER_BIT]
          && bank_a_if.value[`WS_A_BUS0_BIT])
    else $error("Wake flag of the first register not set");

  chk_reserved_zero: assert property (
    RD_VALID |-> (st.last_addr == `WS_ADDR_A) ? (RD_DATA & ~`WS_A_RC_MASK) == `WS_ZERO
               : (st.last_addr == `WS_ADDR_B) ? (RD_DATA & ~`WS_B_RC_MASK) == `WS_ZERO
               : (st.last_addr == `WS_ADDR_LVL) ? (RD_DATA & `WS_LVL_RESTART_ZERO) == `WS_ZERO
               : RD_DATA == `WS_ZERO)
    else $error("Reserved bit read back as one");

  chk_live_wake_pin: assert property (
    (s_quiet ##1 s_read_lvl)
      |=> RD_VALID && RD_DATA[`WS_LVL_WAKE_BIT] == $past(WAKE_INPUT_PIN, 2))
    else $error("Wake pin level misreported");

  chk_dev_mode_inhibit: assert property (
    DEV_MODE |-> ##2 WD_RESET_INHIBIT)
    else $error("Development mode did not inhibit watchdog reset");

  chk_fo_config: assert property (
    (FAIL_OUTPUT_COUNT_SELECT && !SOFT_RESET) |-> ##2 FAIL_OUTPUT_AFTER_FIRST)
    else $error("Fail-output count select not mirrored");

  chk_uv_latched: assert property (
    (BATTERY_SENSE_UV && !SOFT_RESET) ##1 !SOFT_RESET
      |=> bank_b_if.value[`WS_B_UV_BIT])
    else $error("Battery undervoltage not latched");

  chk_uv_held: assert property (
    (bank_b_if.value[`WS_B_UV_BIT] && !bank_b_if.clear && !SOFT_RESET)
      |=> bank_b_if.value[`WS_B_UV_BIT])
    else $error("Latched undervoltage dropped without a clear");

  chk_bus_wake_b: assert property (
    (BUS_WAKE[3] && !SOFT_RESET) |=> bank_b_if.value[`WS_B_BUS1_BIT + 2])
    else $error("Bus channel 3 wake flag not set");

  chk_read_b_value: assert property (
    s_read_b |=> RD_VALID && RD_DATA == $past(bank_b_if.value))
    else $error("Read of the second wake register returned a wrong value");

  chk_clear_with_event: assert property (
    (REG_CLEAR && REG_ADDR == `WS_ADDR_A && WAKE_PIN_WAKE)
      |=> bank_a_if.value[`WS_A_PIN_BIT])
    else $error("Wake event lost to a simultaneous clear");

  chk_unmapped_error: assert property (
    (REG_READ && !is_mapped(REG_ADDR)) |=> RD_ERROR && RD_DATA == `WS_ZERO)
    else $error("Unmapped read not answered with zero and error");

  chk_read_lvl_value: assert property (
    s_read_lvl |=> RD_VALID && !RD_ERROR && RD_DATA == $past(live_level))
    else $error("Read of the live-level register returned a wrong value");

  chk_clear_a_zero: assert property (
    (REG_CLEAR && REG_ADDR == `WS_ADDR_A && set_a == `WS_ZERO && !SOFT_RESET && !RESTART)
      |=> bank_a_if.value == `WS_ZERO)
    else $error("Host clear left a flag of the first register set");

  chk_clear_b_zero: assert property (
    (REG_CLEAR && REG_ADDR == `WS_ADDR_B && set_b == `WS_ZERO && !SOFT_RESET && !RESTART)
      |=> bank_b_if.value == `WS_ZERO)
    else $error("Host clear left a flag of the second register set");

  chk_soft_clear_a: assert property (
    (SOFT_RESET && set_a == `WS_ZERO) |=> bank_a_if.value == `WS_ZERO)
    else $error("Soft reset left a flag of the first register set");

  chk_restart_b_keep: assert property (
    (RESTART && !SOFT_RESET && set_b == `WS_ZERO)
      |=> bank_b_if.value == ($past(bank_b_if.value) & `WS_B_KEEP))
    else $error("Restart did not keep the retained bits of the second register");

  chk_bus_wake_low: assert property (
    (BUS_WAKE[1] && BUS_WAKE[2])
      |=> bank_b_if.value[`WS_B_BUS1_BIT] && bank_b_if.value[`WS_B_BUS1_BIT + 1])
    else $error("Bus channel 1 or 2 wake flag not set");

  chk_failsafe_cfg: assert property (
    live_level[`WS_LVL_CFG1_BIT] |=> !FAILSAFE_ON_WD_FAIL)
    else $error("Fail-safe entry output disagrees with the strap level");

  // Clearing the live register is accepted silently, never flagged
  chk_lvl_clear_quiet: assert property (
    (REG_CLEAR && REG_ADDR == `WS_ADDR_LVL) |=> !RD_ERROR)
    else $error("Clear of the live-level register flagged as an error");

endmodule : wake_source_level_status
`default_nettype wire

// ### tb/host_model.sv
// Host side of the status register port: one-cycle read and clear requests.
// Assumes callers enter the task just after a rising edge of clk.
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk,
  output logic [6:0] reg_addr,
  output logic reg_read,
  output logic reg_clear
);
  initial begin
    reg_addr = 7'h00;
    reg_read = 1'b0;
    reg_clear = 1'b0;
  end

  // Flags are read after each single-source wake and then cleared, so the next source is told apart
  task automatic access(input logic [6:0] addr, input logic rd, input logic clr);
    @(posedge clk);
    #1;
    reg_addr = addr;
    reg_read = rd;
    reg_clear = clr;
    @(posedge clk);
    #1;
    reg_read = 1'b0;
    reg_clear = 1'b0;
    // A released address must not keep looking valid
    reg_addr = ~addr;
  endtask : access
endmodule : host_model
`default_nettype wire

// ### tb/testbench.sv
// Self-checking bench for the wake-source and live-level status registers.
// Assumes the host model owns the register port; the bench drives events and levels.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic valid; logic err; logic [7:0] data;} note_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_reset = 1'b0;
  logic restart = 1'b0;
  logic [6:0] ev = 7'h00;
  logic dev = 1'b1, strap_pin = 1'b1, fail_output_count_select = 1'b1, supply_config_pin = 1'b1, uv = 1'b0, wk = 1'b1;
  logic [6:0] reg_addr;
  logic reg_read, reg_clear, rd_valid, rd_error, wd_inh, fs_wd, fo_first;
  logic [7:0] rd_data;
  logic [7:0] a_exp = 8'h00, b_exp = 8'h00;
  logic strap_exp = 1'b1;
  logic [15:0] seed = 16'h0C59;
  note_t notes[$];
  note_t got_note;
  int fails = 0;
  int cmp_count = 0;

  always #2 clk = ~clk;

  wake_source_level_status wake_source_level_status_i (
    .CLK(clk), .RST_N(rst_n), .SOFT_RESET(soft_reset), .RESTART(restart),
    .REG_ADDR(reg_addr), .REG_READ(reg_read), .REG_CLEAR(reg_clear),
    .RD_DATA(rd_data), .RD_VALID(rd_valid), .RD_ERROR(rd_error),
    .REGULATOR_AUTO_MODE_CHANGE(ev[0]), .BUS_WAKE(ev[4:1]),
    .CYCLIC_TIMER_WAKE(ev[5]), .WAKE_PIN_WAKE(ev[6]), .WAKE_INPUT_PIN(wk),
    .BATTERY_SENSE_UV(uv), .DEV_MODE(dev), .INTERRUPT_OUT_PIN(strap_pin),
    .FAIL_OUTPUT_COUNT_SELECT(fail_output_count_select), .SUPPLY_CONFIG_PIN(supply_config_pin),
    .WD_RESET_INHIBIT(wd_inh), .FAILSAFE_ON_WD_FAIL(fs_wd),
    .FAIL_OUTPUT_AFTER_FIRST(fo_first)
  );

  host_model host_model_i (
    .clk(clk), .reg_addr(reg_addr), .reg_read(reg_read), .reg_clear(reg_clear)
  );

  function automatic logic [15:0] lfsr(input logic [15:0] r);
    return {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
  endfunction : lfsr

  function automatic logic [7:0] lvl();
    return {dev, strap_exp, fail_output_count_select, supply_config_pin, uv, 2'b00, wk};
  endfunction : lvl

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic rd(input logic [6:0] addr, input logic [7:0] exp);
    notes.push_back('{1'b1, 1'b0, exp});
    host_model_i.access(addr, 1'b1, 1'b0);
  endtask : rd

  task automatic clr(input logic [6:0] addr, input logic err);
    if (err) begin
      notes.push_back('{1'b0, 1'b1, 8'h00});
    end
    host_model_i.access(addr, 1'b0, 1'b1);
  endtask : clr

  task automatic rd_all();
    rd(7'h46, a_exp);
    rd(7'h48, lvl());
    rd(7'h49, b_exp);
  endtask : rd_all

  task automatic outs();
    check("cfg outputs", {5'h00, dev, ~strap_exp, fail_output_count_select}, {5'h00, wd_inh, fs_wd, fo_first});
  endtask : outs

  // Event bits: 0 mode change, 1..4 bus 0..3, 5 cyclic timer, 6 wake pin
  task automatic pulse(input logic [6:0] e);
    @(posedge clk);
    #1;
    ev = e;
    @(posedge clk);
    #1;
    ev = 7'h00;
    a_exp |= {e[0], 1'b0, e[1], e[5], 3'b000, e[6]};
    b_exp |= {5'b00000, e[4], e[3], e[2]};
  endtask : pulse

  task automatic strobe(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask : strobe

  // Answers are taken off the queue in order; a missing answer leaves a note behind
  always @(negedge clk) begin
    if (rd_valid === 1'b1 || rd_error === 1'b1) begin
      if (notes.size() == 0) begin
        fails++;
        $display("BAD answer expected none seen %h", rd_data);
      end else begin
        got_note = notes.pop_front();
        check("rd_error", {7'h00, got_note.err}, {7'h00, rd_error});
        if (got_note.valid) begin
          check("rd_data", got_note.data, rd_data);
        end
      end
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    outs();
    rd_all();
    for (int i = 0; i < 7; i++) begin
      pulse(7'h01 << i);
      repeat (3) @(posedge clk);
      rd_all();
      clr(7'h46, 1'b0);
      clr(7'h49, 1'b0);
      a_exp = 8'h00;
      b_exp = 8'h00;
      rd_all();
    end
    // A wake landing in the clear cycle must survive the clear
    fork
      pulse(7'h40);
      clr(7'h46, 1'b0);
    join
    rd(7'h46, 8'h01);
    notes.push_back('{1'b1, 1'b0, 8'h01});
    host_model_i.access(7'h46, 1'b1, 1'b1);
    a_exp = 8'h00;
    rd(7'h46, 8'h00);
    notes.push_back('{1'b1, 1'b1, 8'h00});
    host_model_i.access(7'h47, 1'b1, 1'b0);
    clr(7'h7F, 1'b1);
    uv = 1'b1;
    repeat (3) @(posedge clk);
    b_exp[7] = 1'b1;
    rd(7'h48, lvl());
    rd(7'h49, b_exp);
    uv = 1'b0;
    repeat (3) @(posedge clk);
    rd(7'h49, b_exp);
    pulse(7'h7F);
    clr(7'h48, 1'b0);
    strobe(restart);
    rd_all();
    strap_pin = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    outs();
    strobe(soft_reset);
    strap_exp = 1'b0;
    a_exp = 8'h00;
    b_exp = 8'h00;
    repeat (3) @(posedge clk);
    #1;
    rd_all();
    outs();
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      {wk, uv, supply_config_pin, fail_output_count_select, dev} = seed[11:7];
      pulse(seed[6:0]);
      b_exp[7] = b_exp[7] | uv;
      repeat (2) @(posedge clk);
      rd_all();
      outs();
    end
    for (int n = 0; n < 20 && notes.size() != 0; n++) begin
      @(posedge clk);
    end
    if (notes.size() != 0) begin
      fails++;
      $display("BAD answers expected %0d seen %0d", notes.size(), 0);
    end
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("BAD run length expected %0d seen %0d", 20000, 20000);
    conclude();
  end

  task automatic conclude();
    $display("Comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : conclude
endmodule : testbench
`default_nettype wire
